// File: logic/reim_cfg.svh
// Offsets, field positions, reset values and command codes of the event mask block
`ifndef REIM_CFG_SVH
`define REIM_CFG_SVH

// ****************************************
// Register offsets (11-bit memory address)
// ****************************************
`define REIM_ADDR_W 11
`define REIM_OFS_ENABLE_LOW 11'h100
`define REIM_OFS_WAKE_COUNT_LO 11'h102
`define REIM_OFS_WAKE_COUNT_HI 11'h103
`define REIM_OFS_WAKE_LIMIT_LO 11'h104
`define REIM_OFS_WAKE_LIMIT_HI 11'h105
`define REIM_OFS_LEVEL_LIMIT 11'h108
`define REIM_OFS_FLAGS_LOW 11'h336
`define REIM_OFS_FLAGS_HIGH 11'h337

// ****************************************
// Reset values
// ****************************************
`define REIM_RST_ENABLE_LOW 8'h00
`define REIM_RST_FLAGS 8'h00
`define REIM_RST_WAKE_COUNT 16'h0000
`define REIM_RST_WAKE_LIMIT 16'h0000
`define REIM_RST_LEVEL_LIMIT 8'h00

// ****************************************
// Event bit positions
// ****************************************
`define REIM_BIT_WAKE_COUNT 7
`define REIM_BIT_SMART_WAKE 6
`define REIM_BIT_CIPHER_DONE 5
`define REIM_BIT_TX_END 4
`define REIM_BIT_ADDR_MATCH 3
`define REIM_BIT_CRC_OK 2
`define REIM_BIT_SYNC_DET 1
`define REIM_BIT_PREAMBLE_DET 0

// ****************************************
// Serial commands and level offset
// ****************************************
`define REIM_CMD_MEM_WR 5'h03
`define REIM_CMD_MEM_RD 5'h07
`define REIM_LEVEL_OFFSET_DBM 10'h06B

`endif

// File: logic/reim_pkg.sv
// Types shared by the event mask block
package reim_pkg;
    typedef logic [7:0] reim_byte_t;
    typedef logic [10:0] reim_addr_t;
    typedef enum logic [3:0] {
        REIM_ST_CMD = 4'h1,
        REIM_ST_ADDR = 4'h2,
        REIM_ST_DATA = 4'h4,
        REIM_ST_SKIP = 4'h8
    } reim_state_e;
endpackage

// File: logic/reim_byte_if.sv
// Byte-level link between the serial shifter and the command decoder
`timescale 1ns/1ns
interface reim_byte_if;
    import reim_pkg::*;
    logic frame_active;
    logic rx_valid;
    reim_byte_t rx_byte;
    logic tx_load;
    reim_byte_t tx_byte;
    modport shifter (output frame_active, output rx_valid, output rx_byte,
                     input tx_load, input tx_byte);
    modport decoder (input frame_active, input rx_valid, input rx_byte,
                     output tx_load, output tx_byte);
endinterface

// File: logic/reim_spi_shift.sv
// Serial shifter: mode 0 bytes in on rising clock, out on falling clock
`timescale 1ns/1ns
module reim_spi_shift (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    reim_byte_if.shifter bus
);
    import reim_pkg::*;
    logic sclk_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sh_q;
    reim_byte_t tx_sh_q;
    logic rx_valid_q;
    reim_byte_t rx_byte_q;
    logic rise;
    logic fall;

    assign rise = spi_sclk_i & ~sclk_q;
    assign fall = ~spi_sclk_i & sclk_q;
    assign bus.frame_active = ~spi_cs_n_i;
    assign bus.rx_valid = rx_valid_q;
    assign bus.rx_byte = rx_byte_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk_i;
        end
    end

    // Receive path
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt_q <= 3'h0;
            rx_sh_q <= 7'h00;
            rx_valid_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            rx_valid_q <= 1'b0;
            if (spi_cs_n_i) begin
                bit_cnt_q <= 3'h0;
            end else if (rise) begin
                rx_sh_q <= {rx_sh_q[5:0], spi_mosi_i};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    rx_valid_q <= 1'b1;
                    rx_byte_q <= {rx_sh_q, spi_mosi_i};
                end
            end
        end
    end

    // Transmit path
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_sh_q <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (spi_cs_n_i) begin
            tx_sh_q <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (bus.tx_load) begin
            tx_sh_q <= bus.tx_byte;
        end else if (fall) begin
            spi_miso_o <= tx_sh_q[7];
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
    end
endmodule // reim_spi_shift

// File: logic/reim_event_gen.sv
// Event qualification: wake count compare, level compare, cipher gating
`timescale 1ns/1ns
`include "reim_cfg.svh"
module reim_event_gen (
    input wire logic wake_tick_i,
    input wire logic [15:0] wake_count_i,
    input wire logic [15:0] wake_count_limit_i,
    input wire logic smart_wake_operation_i,
    input wire logic level_valid_i,
    input wire logic signed [7:0] level_dbm_i,
    input wire logic [7:0] smart_wake_level_limit_i,
    input wire logic cipher_loaded_i,
    input wire logic cipher_done_i,
    input wire logic tx_end_i,
    input wire logic addr_match_i,
    input wire logic crc_ok_i,
    input wire logic sync_det_i,
    input wire logic preamble_det_i,
    output logic [7:0] event_o,
    output logic wake_exceed_o
);
    logic [15:0] count_next;
    logic signed [9:0] level_ext;
    logic signed [9:0] limit_dbm;

    assign count_next = wake_count_i + 16'h0001;
    assign level_ext = {{2{level_dbm_i[7]}}, level_dbm_i};
    assign limit_dbm = $signed({2'b00, smart_wake_level_limit_i} - `REIM_LEVEL_OFFSET_DBM);

    always_comb begin
        event_o = 8'h00;
        event_o[`REIM_BIT_WAKE_COUNT] = wake_tick_i & (count_next == wake_count_limit_i);
        event_o[`REIM_BIT_SMART_WAKE] = smart_wake_operation_i & level_valid_i
                                        & (level_ext > limit_dbm);
        event_o[`REIM_BIT_CIPHER_DONE] = cipher_loaded_i & cipher_done_i;
        event_o[`REIM_BIT_TX_END] = tx_end_i;
        event_o[`REIM_BIT_ADDR_MATCH] = addr_match_i;
        event_o[`REIM_BIT_CRC_OK] = crc_ok_i;
        event_o[`REIM_BIT_SYNC_DET] = sync_det_i;
        event_o[`REIM_BIT_PREAMBLE_DET] = preamble_det_i;
    end

    assign wake_exceed_o = wake_tick_i & (count_next > wake_count_limit_i);
endmodule // reim_event_gen

// File: logic/reim_top.sv
// Radio event interrupt mask: serial memory access, mask, flags and host interrupt
//
// ****************************************
// How it works
// ****************************************
// How it works
// - With mask bit 7 set, a flag is raised when the wake-up count reaches the wake-up limit.
// - With mask bit 6 set, a flag is raised when the smart-wake level beats its threshold.
// - With mask bit 5 set, a flag is raised on cipher completion, only if the cipher is loaded.
// - With mask bit 4 set, a flag is raised when a transmitted packet has ended.
// - With mask bit 3 set, a flag is raised when a received packet matches an address.
// - With mask bit 2 set, a flag is raised when a received packet passes its CRC.
// - With mask bit 1 set, a flag is raised when a qualified sync word is seen.
// - With mask bit 0 set, a flag is raised when a qualified preamble is seen.
// - Each mask bit written as one enables its event and as zero disables it.
// - When the wake-up count passes its limit, the radio is sent back to the idle-off state.
// - The smart-wake threshold in dBm is the programmed limit value minus 107.
`timescale 1ns/1ns
`include "reim_cfg.svh"
module reim_top (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic wake_timer_tick_i,
    input wire logic smart_wake_operation_i,
    input wire logic level_valid_i,
    input wire logic signed [7:0] level_dbm_i,
    input wire logic cipher_loaded_i,
    input wire logic cipher_done_i,
    input wire logic tx_end_i,
    input wire logic addr_match_i,
    input wire logic crc_ok_i,
    input wire logic sync_det_i,
    input wire logic preamble_det_i,
    output logic irq_o,
    output logic radio_idle_off_req_o
);
    import reim_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    reim_byte_if link ();

    reim_state_e state_q;
    reim_state_e state_d;
    logic is_write_q;
    logic [2:0] addr_hi_q;
    reim_addr_t addr_q;
    reim_addr_t wr_addr;
    reim_addr_t rd_addr;
    logic wr_en;
    reim_byte_t wr_data;
    reim_byte_t tx_byte;
    logic tx_load;

    reim_byte_t enable_low_q;
    reim_byte_t flags_low_q;
    reim_byte_t flags_high_q;
    logic [15:0] wake_count_q;
    logic [15:0] wake_count_limit_q;
    reim_byte_t smart_wake_level_limit_q;

    logic [7:0] event_raw;
    logic wake_exceed;

    // ****************************************
    // Register read decode
    // ****************************************
    function automatic reim_byte_t reg_read(input reim_addr_t a);
        reim_byte_t r;
        r = 8'h00;
        case (a)
            `REIM_OFS_ENABLE_LOW: begin
                r = enable_low_q;
            end
            `REIM_OFS_WAKE_COUNT_LO: begin
                r = wake_count_q[7:0];
            end
            `REIM_OFS_WAKE_COUNT_HI: begin
                r = wake_count_q[15:8];
            end
            `REIM_OFS_WAKE_LIMIT_LO: begin
                r = wake_count_limit_q[7:0];
            end
            `REIM_OFS_WAKE_LIMIT_HI: begin
                r = wake_count_limit_q[15:8];
            end
            `REIM_OFS_LEVEL_LIMIT: begin
                r = smart_wake_level_limit_q;
            end
            `REIM_OFS_FLAGS_LOW: begin
                r = flags_low_q;
            end
            `REIM_OFS_FLAGS_HIGH: begin
                r = flags_high_q;
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return r;
    endfunction

    // ****************************************
    // Serial shifter
    // ****************************************
    reim_spi_shift u_shift (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o),
        .bus(link.shifter)
    );

    assign link.tx_load = tx_load;
    assign link.tx_byte = tx_byte;

    // ****************************************
    // Command decoder
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            REIM_ST_CMD: begin
                if (link.rx_valid) begin
                    if (link.rx_byte[7:3] == `REIM_CMD_MEM_WR ||
                        link.rx_byte[7:3] == `REIM_CMD_MEM_RD) begin
                        state_d = REIM_ST_ADDR;
                    end else begin
                        state_d = REIM_ST_SKIP;
                    end
                end
            end
            REIM_ST_ADDR: begin
                if (link.rx_valid) begin
                    state_d = REIM_ST_DATA;
                end
            end
            REIM_ST_DATA: begin
                state_d = REIM_ST_DATA;
            end
            REIM_ST_SKIP: begin
                state_d = REIM_ST_SKIP;
            end
            default: begin
                state_d = REIM_ST_CMD;
            end
        endcase
        if (!link.frame_active) begin
            state_d = REIM_ST_CMD;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= REIM_ST_CMD;
        end else begin
            state_q <= state_d;
        end
    end

    // Command kind and upper address bits
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            is_write_q <= 1'b0;
            addr_hi_q <= 3'h0;
        end else if (state_q == REIM_ST_CMD && link.rx_valid) begin
            is_write_q <= (link.rx_byte[7:3] == `REIM_CMD_MEM_WR);
            addr_hi_q <= link.rx_byte[2:0];
        end
    end

    // Sequential address pointer
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_q <= 11'h000;
        end else if (link.rx_valid) begin
            if (state_q == REIM_ST_ADDR) begin
                addr_q <= {addr_hi_q, link.rx_byte};
            end else if (state_q == REIM_ST_DATA) begin
                addr_q <= addr_q + 11'h001;
            end
        end
    end

    assign wr_en = link.rx_valid && (state_q == REIM_ST_DATA) && is_write_q;
    assign wr_addr = addr_q;
    assign wr_data = link.rx_byte;
    assign rd_addr = (state_q == REIM_ST_ADDR) ? {addr_hi_q, link.rx_byte}
                                                : addr_q + 11'h001;
    assign tx_load = link.rx_valid && !is_write_q &&
                     (state_q == REIM_ST_ADDR || state_q == REIM_ST_DATA);
    // Procedural so that a register change also refreshes the loaded byte
    always_comb begin
        tx_byte = reg_read(rd_addr);
    end

    // ****************************************
    // Event qualification
    // ****************************************
    reim_event_gen u_events (
        .wake_tick_i(wake_timer_tick_i),
        .wake_count_i(wake_count_q),
        .wake_count_limit_i(wake_count_limit_q),
        .smart_wake_operation_i(smart_wake_operation_i),
        .level_valid_i(level_valid_i),
        .level_dbm_i(level_dbm_i),
        .smart_wake_level_limit_i(smart_wake_level_limit_q),
        .cipher_loaded_i(cipher_loaded_i),
        .cipher_done_i(cipher_done_i),
        .tx_end_i(tx_end_i),
        .addr_match_i(addr_match_i),
        .crc_ok_i(crc_ok_i),
        .sync_det_i(sync_det_i),
        .preamble_det_i(preamble_det_i),
        .event_o(event_raw),
        .wake_exceed_o(wake_exceed)
    );

    // ****************************************
    // Mask and configuration registers
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_low_q <= `REIM_RST_ENABLE_LOW;
        end else if (wr_en && wr_addr == `REIM_OFS_ENABLE_LOW) begin
            enable_low_q <= wr_data;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_count_limit_q <= `REIM_RST_WAKE_LIMIT;
            smart_wake_level_limit_q <= `REIM_RST_LEVEL_LIMIT;
        end else if (wr_en) begin
            if (wr_addr == `REIM_OFS_WAKE_LIMIT_LO) begin
                wake_count_limit_q[7:0] <= wr_data;
            end
            if (wr_addr == `REIM_OFS_WAKE_LIMIT_HI) begin
                wake_count_limit_q[15:8] <= wr_data;
            end
            if (wr_addr == `REIM_OFS_LEVEL_LIMIT) begin
                smart_wake_level_limit_q <= wr_data;
            end
        end
    end

    // Wake-up counter: host write wins over a tick
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_count_q <= `REIM_RST_WAKE_COUNT;
        end else if (wr_en && wr_addr == `REIM_OFS_WAKE_COUNT_LO) begin
            wake_count_q[7:0] <= wr_data;
        end else if (wr_en && wr_addr == `REIM_OFS_WAKE_COUNT_HI) begin
            wake_count_q[15:8] <= wr_data;
        end else if (wake_timer_tick_i) begin
            wake_count_q <= wake_count_q + 16'h0001;
        end
    end

    // ****************************************
    // Event flags: write one to clear, set wins
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_low_q <= `REIM_RST_FLAGS;
        end else begin
            flags_low_q <= (flags_low_q
                            & ~((wr_en && wr_addr == `REIM_OFS_FLAGS_LOW) ? wr_data : 8'h00))
                           | (event_raw & enable_low_q);
        end
    end

    // No sources of its own here; only clearable
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_high_q <= `REIM_RST_FLAGS;
        end else if (wr_en && wr_addr == `REIM_OFS_FLAGS_HIGH) begin
            flags_high_q <= flags_high_q & ~wr_data;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_low_q & enable_low_q);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            radio_idle_off_req_o <= 1'b0;
        end else begin
            radio_idle_off_req_o <= wake_exceed;
        end
    end
endmodule // reim_top

// File: testbench/reim_monitor.sv
// Checker of the host interrupt, idle-off request and serial output
`timescale 1ns/1ns
module reim_monitor (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic wake_timer_tick_i,
    input wire logic smart_wake_operation_i,
    input wire logic level_valid_i,
    input wire logic cipher_loaded_i,
    input wire logic cipher_done_i,
    input wire logic tx_end_i,
    input wire logic addr_match_i,
    input wire logic crc_ok_i,
    input wire logic sync_det_i,
    input wire logic preamble_det_i,
    input wire logic irq_o,
    input wire logic radio_idle_off_req_o
);
    logic real_evt;
    assign real_evt = tx_end_i | addr_match_i | crc_ok_i | sync_det_i | preamble_det_i
        | (cipher_done_i & cipher_loaded_i) | (level_valid_i & smart_wake_operation_i)
        | wake_timer_tick_i;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // ****************************************
    // Assertions
    // ****************************************
    sequence s_only_gated(logic g);
        g && !real_evt && spi_cs_n_i && $past(spi_cs_n_i) ##1 !real_evt && spi_cs_n_i;
    endsequence
    property p_gated(logic g);
        s_only_gated(g) |=> !$rose(irq_o);
    endproperty
    AST_IRQ_CAUSE: assert property (
        $rose(irq_o) |-> $past(real_evt, 2) || !$past(spi_cs_n_i, 2))
        else $error("interrupt rose without an event or host write");
    AST_IRQ_HOLD: assert property (
        $fell(irq_o) |-> !$past(spi_cs_n_i, 2))
        else $error("interrupt dropped without a host write");
    AST_LEVEL_GATE: assert property (
        p_gated(level_valid_i && !smart_wake_operation_i))
        else $error("level event outside smart wake raised the interrupt");
    AST_CIPHER_GATE: assert property (
        p_gated(cipher_done_i && !cipher_loaded_i))
        else $error("cipher event without cipher module raised the interrupt");
    AST_IDLE_CAUSE: assert property (
        radio_idle_off_req_o |-> $past(wake_timer_tick_i))
        else $error("idle-off request without a wake tick");
    AST_IDLE_PULSE: assert property (
        radio_idle_off_req_o && !wake_timer_tick_i |=> !radio_idle_off_req_o)
        else $error("idle-off request longer than one cycle");
    AST_MISO_IDLE: assert property (
        spi_cs_n_i && $past(spi_cs_n_i) && $past(spi_cs_n_i, 2) && $past(spi_cs_n_i, 3)
        |-> !spi_miso_o)
        else $error("serial output not low outside a frame");
    AST_MISO_EDGE: assert property (
        $changed(spi_miso_o) && !spi_cs_n_i && !$past(spi_cs_n_i) |-> !$past(spi_sclk_i))
        else $error("serial output changed while serial clock high");
endmodule // reim_monitor

bind reim_top reim_monitor reim_monitor_inst (
    .clk_sys_i, .sys_rst_i, .spi_sclk_i, .spi_cs_n_i, .spi_miso_o, .wake_timer_tick_i,
    .smart_wake_operation_i, .level_valid_i, .cipher_loaded_i, .cipher_done_i, .tx_end_i,
    .addr_match_i, .crc_ok_i, .sync_det_i, .preamble_det_i, .irq_o, .radio_idle_off_req_o
);

// File: testbench/reim_host_model.sv
// Host controller model: mode 0 serial frames of three bytes
`timescale 1ns/1ns
module reim_host_model (
    input wire logic clk_sys_i,
    input wire logic spi_miso_i,
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // Clock held low and high four cycles each; data out while low
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         output logic [7:0] rd);
        logic [23:0] sh;
        sh = {b0, b1, b2};
        @(posedge clk_sys_i);
        spi_cs_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi_o <= sh[i];
            repeat (4) @(posedge clk_sys_i);
            spi_sclk_o <= 1'b1;
            rd = {rd[6:0], spi_miso_i};
            repeat (4) @(posedge clk_sys_i);
            spi_sclk_o <= 1'b0;
        end
        repeat (3) @(posedge clk_sys_i);
        spi_cs_n_o <= 1'b1;
        spi_mosi_o <= ~spi_mosi_o;
        @(posedge clk_sys_i);
    endtask
endmodule // reim_host_model

// File: testbench/radio_event_interrupt_mask_tb.sv
// Self-checking bench of the radio event interrupt mask
`timescale 1ns/1ns
`include "reim_cfg.svh"
module radio_event_interrupt_mask_tb;
    import reim_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic sclk, cs_n, mosi, miso, irq, idle_req;
    logic smart_wake = 1'b0;
    logic cipher_loaded = 1'b1;
    logic signed [7:0] level_dbm = 8'h00;
    logic [7:0] evt = 8'h00;
    logic [7:0] bit_m;
    reim_byte_t rd;
    int error_cnt = 0;
    int num_checks = 0;
    int idle_cnt = 0;
    reim_addr_t rst_addr[9] = '{`REIM_OFS_ENABLE_LOW, `REIM_OFS_WAKE_COUNT_LO,
        `REIM_OFS_WAKE_COUNT_HI, `REIM_OFS_WAKE_LIMIT_LO, `REIM_OFS_WAKE_LIMIT_HI,
        `REIM_OFS_LEVEL_LIMIT, `REIM_OFS_FLAGS_LOW, `REIM_OFS_FLAGS_HIGH, 11'h101};
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (idle_req === 1'b1) idle_cnt++;
    reim_top reim_top_inst (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .wake_timer_tick_i(evt[7]),
        .smart_wake_operation_i(smart_wake), .level_valid_i(evt[6]), .level_dbm_i(level_dbm),
        .cipher_loaded_i(cipher_loaded), .cipher_done_i(evt[5]), .tx_end_i(evt[4]),
        .addr_match_i(evt[3]), .crc_ok_i(evt[2]), .sync_det_i(evt[1]),
        .preamble_det_i(evt[0]), .irq_o(irq), .radio_idle_off_req_o(idle_req));
    reim_host_model reim_host_model_inst (.clk_sys_i(clk_sys), .spi_miso_i(miso),
        .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk8(input reim_byte_t got, input reim_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected byte at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected bit at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input reim_addr_t a, input reim_byte_t d);
        reim_host_model_inst.frame({`REIM_CMD_MEM_WR, a[10:8]}, a[7:0], d, rd);
    endtask
    task automatic rd_chk(input reim_addr_t a, input reim_byte_t exp);
        reim_host_model_inst.frame({`REIM_CMD_MEM_RD, a[10:8]}, a[7:0], 8'hFF, rd);
        chk8(rd, exp);
    endtask
    task automatic fire(input logic [7:0] m);
        @(posedge clk_sys);
        evt <= m;
        @(posedge clk_sys);
        evt <= 8'h00;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00);
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'hA5);
        rd_chk(`REIM_OFS_ENABLE_LOW, 8'hA5);
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'h5A);
        rd_chk(`REIM_OFS_ENABLE_LOW, 8'h5A);
        reg_wr(11'h101, 8'hFF);
        rd_chk(11'h101, 8'h00);
        reim_host_model_inst.frame(8'h10, 8'h00, 8'hFF, rd);
        reim_host_model_inst.frame(8'h09, 8'h00, 8'h00, rd);
        rd_chk(`REIM_OFS_ENABLE_LOW, 8'h5A);
        for (int i = 0; i < 6; i++) begin
            bit_m = 8'h01 << i;
            reg_wr(`REIM_OFS_ENABLE_LOW, ~bit_m);
            fire(bit_m);
            chk1(irq, 1'b0);
            rd_chk(`REIM_OFS_FLAGS_LOW, 8'h00);
            reg_wr(`REIM_OFS_ENABLE_LOW, bit_m);
            fire(bit_m);
            chk1(irq, 1'b1);
            rd_chk(`REIM_OFS_FLAGS_LOW, bit_m);
            chk1(irq, 1'b1);
            reg_wr(`REIM_OFS_FLAGS_LOW, bit_m);
            chk1(irq, 1'b0);
        end
        cipher_loaded <= 1'b0;
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'h20);
        fire(8'h20);
        rd_chk(`REIM_OFS_FLAGS_LOW, 8'h00);
        reg_wr(`REIM_OFS_LEVEL_LIMIT, 8'h14);
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'h40);
        smart_wake <= 1'b1;
        level_dbm <= 8'hA9;
        fire(8'h40);
        rd_chk(`REIM_OFS_FLAGS_LOW, 8'h00);
        level_dbm <= 8'hAA;
        fire(8'h40);
        chk1(irq, 1'b1);
        reg_wr(`REIM_OFS_FLAGS_LOW, 8'hFF);
        smart_wake <= 1'b0;
        level_dbm <= 8'h7F;
        fire(8'h40);
        rd_chk(`REIM_OFS_FLAGS_LOW, 8'h00);
        reg_wr(`REIM_OFS_WAKE_COUNT_LO, 8'hFF);
        reg_wr(`REIM_OFS_WAKE_LIMIT_HI, 8'h01);
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'h80);
        fire(8'h80);
        chk1(irq, 1'b1);
        chk8(8'(idle_cnt), 8'h00);
        rd_chk(`REIM_OFS_WAKE_COUNT_LO, 8'h00);
        rd_chk(`REIM_OFS_WAKE_COUNT_HI, 8'h01);
        reg_wr(`REIM_OFS_FLAGS_LOW, 8'h80);
        fire(8'h80);
        chk1(irq, 1'b0);
        chk8(8'(idle_cnt), 8'h01);
        reg_wr(`REIM_OFS_WAKE_LIMIT_LO, 8'h3C);
        rd_chk(`REIM_OFS_WAKE_LIMIT_LO, 8'h3C);
        reg_wr(`REIM_OFS_FLAGS_HIGH, 8'hFF);
        rd_chk(`REIM_OFS_FLAGS_HIGH, 8'h00);
        reg_wr(`REIM_OFS_ENABLE_LOW, 8'h10);
        fire(8'h10);
        chk1(irq, 1'b1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk1(irq, 1'b0);
        rd_chk(`REIM_OFS_FLAGS_LOW, 8'h00);
        rd_chk(`REIM_OFS_WAKE_LIMIT_LO, 8'h00);
        rd_chk(`REIM_OFS_ENABLE_LOW, 8'h00);
        wrap_up();
    end
endmodule // radio_event_interrupt_mask_tb
